/* File: design/cdh_pkg.sv */
// Purpose: shared constants and types for the card host controller
// Assumes: 100 MHz clock_i, one clock domain
// Notes: timing counts are derived from the nanosecond figures below
package cdh_pkg;
	// clock rate
	localparam int CLK_MHZ = 100;
	// bus, count and timer widths and stream depth
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int COUNT_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int TIMER_W = 8;
	// strobe timing in ns
	localparam int SETUP_NS = 30;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 20;
	// least times round up to whole cycles
	localparam logic [TIMER_W-1:0] SETUP_CYC = TIMER_W'((SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TIMER_W-1:0] STROBE_CYC = TIMER_W'((STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TIMER_W-1:0] HOLD_CYC = TIMER_W'((HOLD_NS * CLK_MHZ + 999) / 1000);
	// pin values: reset and idle levels, word card enable, byte pad
	localparam logic STROBE_IDLE_N = 1'b1;
	localparam logic [1:0] CARD_ENABLE_IDLE_N = 2'b11;
	localparam logic [1:0] CARD_ENABLE_WORD_N = 2'b00;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 4'h0;
	localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
	localparam logic [7:0] BYTE_PAD = 8'h00;
	localparam logic REQUEST_IDLE = 1'b0;
	localparam logic ACK_IDLE_N = 1'b1;
	// this host has hardware support for dma
	localparam logic DMA_SUPPORTED = 1'b1;
	// card operating modes
	typedef enum logic [1:0] {
		MODE_MEMORY_ONLY,
		MODE_IO_CARD,
		MODE_DISK_EMULATION
	} cdh_mode_e;
	// user commands
	typedef enum logic [2:0] {
		CMD_REG_READ,
		CMD_REG_WRITE,
		CMD_IO_READ,
		CMD_DMA_READ,
		CMD_DMA_WRITE
	} cdh_cmd_e;
endpackage

/* File: design/cdh_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: out_data comes from the storage array at the read pointer
`timescale 1ns/1ps
module cdh_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	// honest full and empty from the fill count
	assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rptr_reg];

	// storage write
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wptr_reg] <= in_data_i;
		end
	end

	// pointers and count
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // cdh_fifo

/* File: design/cdh_card_host.sv */
// Purpose: host-side controller driving a removable storage card's port
// Assumes: card pins sampled on clock_i; pin outputs come from flip-flops
// Notes: one command at a time; dma read data streams through a fifo
// Contract
// - disk mode: register accesses byte wide on low lane, data transfers sixteen bit
// - host may gate its input data buffers with input acknowledge
// - host sets dma direction by pulsing dma read or write strobe
// - during dma both register selects stay negated, transfers sixteen bit
// - host without dma support reports dma unavailable to software
// - host asserts dma acknowledge in answer to dma request
// - host drives attribute select low during io cycles
// - disk mode: first select for task file, second for control block
`timescale 1ns/1ps
module cdh_card_host (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire cdh_pkg::cdh_mode_e mode_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire cdh_pkg::cdh_cmd_e cmd_kind_i,
	input wire logic cmd_ctrl_i,
	input wire logic [cdh_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [cdh_pkg::DATA_W-1:0] cmd_wdata_i,
	input wire logic [cdh_pkg::COUNT_W-1:0] cmd_count_i,
	output logic rsp_valid_o,
	output logic [cdh_pkg::DATA_W-1:0] rsp_data_o,
	output logic rsp_error_o,
	output logic rsp_ack_seen_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [cdh_pkg::DATA_W-1:0] rd_data_o,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [cdh_pkg::DATA_W-1:0] wr_data_i,
	output logic dma_available_o,
	output logic dma_busy_o,
	output logic [cdh_pkg::ADDR_W-1:0] addr_o,
	output logic taskfile_select_n_o,
	output logic control_block_select_n_o,
	output logic [1:0] card_enable_n_o,
	output logic attr_select_n_o,
	output logic io_read_strobe_n_o,
	output logic io_write_strobe_n_o,
	output logic dma_read_strobe_n_o,
	output logic dma_write_strobe_n_o,
	output logic dma_ack_n_o,
	input wire logic dma_request_i,
	input wire logic input_ack_n_i,
	input wire logic [cdh_pkg::DATA_W-1:0] data_i,
	output logic [cdh_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o
);
	localparam int SW = cdh_pkg::DATA_W + 2;
	localparam logic [SW-1:0] SYNC_RST = {cdh_pkg::REQUEST_IDLE, cdh_pkg::ACK_IDLE_N,
		cdh_pkg::DATA_IDLE};
	typedef enum logic [3:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESP,
		ST_DMA_WAIT, ST_DMA_SETUP, ST_DMA_STROBE, ST_DMA_RECOV} cdh_state_e;
	cdh_state_e state_reg, state_next;
	cdh_pkg::cdh_cmd_e kind_reg;
	logic [cdh_pkg::ADDR_W-1:0] addr_reg;
	logic [cdh_pkg::DATA_W-1:0] wdata_reg, rdata_reg, data_s;
	logic [cdh_pkg::COUNT_W-1:0] remain_reg;
	logic [cdh_pkg::TIMER_W-1:0] cnt_reg;
	logic [SW-1:0] sync1_reg, sync2_reg;
	logic ctrl_reg, err_reg, ack_seen_reg, req_s, ack_n_s, done, legal, is_dma_cmd;
	logic in_cycle, is_reg_op, is_read_op, in_dma, fifo_in_valid, fifo_in_ready;

	// two-stage synchronisers for all card inputs
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
		end else begin
			sync1_reg <= {dma_request_i, input_ack_n_i, data_i};
			sync2_reg <= sync1_reg;
		end
	end
	assign req_s = sync2_reg[SW-1];
	assign ack_n_s = sync2_reg[SW-2];
	assign data_s = sync2_reg[cdh_pkg::DATA_W-1:0];
	// command legality per mode
	always_comb begin
		is_dma_cmd = (cmd_kind_i == cdh_pkg::CMD_DMA_READ) ||
			(cmd_kind_i == cdh_pkg::CMD_DMA_WRITE);
		case (cmd_kind_i)
			cdh_pkg::CMD_REG_READ,
			cdh_pkg::CMD_REG_WRITE: legal = (mode_i == cdh_pkg::MODE_DISK_EMULATION);
			cdh_pkg::CMD_IO_READ: legal = (mode_i == cdh_pkg::MODE_IO_CARD);
			cdh_pkg::CMD_DMA_READ,
			cdh_pkg::CMD_DMA_WRITE: legal = (mode_i == cdh_pkg::MODE_DISK_EMULATION) &&
				(cmd_count_i != '0) && cdh_pkg::DMA_SUPPORTED;
			default: legal = 1'b0;
		endcase
	end
	assign done = (cnt_reg == '0);
	assign fifo_in_valid = (state_reg == ST_DMA_STROBE) && done &&
		(kind_reg == cdh_pkg::CMD_DMA_READ);
	// sequencing of register, io and dma cycles
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					if (!legal) begin
						state_next = ST_RESP;
					end else if (is_dma_cmd) begin
						state_next = ST_DMA_WAIT;
					end else begin
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: if (done) state_next = ST_STROBE;
			ST_STROBE: if (done) state_next = ST_HOLD;
			ST_HOLD: if (done) state_next = ST_RESP;
			ST_RESP: state_next = ST_IDLE;
			ST_DMA_WAIT: if (req_s) state_next = ST_DMA_SETUP;
			ST_DMA_SETUP: begin
				// back-pressure: a word starts only when it has room or data
				if (done && ((kind_reg == cdh_pkg::CMD_DMA_READ) ? fifo_in_ready : wr_valid_i)) begin
					state_next = ST_DMA_STROBE;
				end
			end
			ST_DMA_STROBE: if (done) state_next = ST_DMA_RECOV;
			ST_DMA_RECOV: begin
				if (done) begin
					if (remain_reg == '0) begin
						state_next = ST_RESP;
					end else if (req_s) begin
						state_next = ST_DMA_SETUP;
					end else begin
						state_next = ST_DMA_WAIT;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end
	// state register
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end
	// phase timer, reloaded on every state change
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cnt_reg <= '0;
		end else if (state_next != state_reg) begin
			case (state_next)
				ST_SETUP, ST_DMA_SETUP: cnt_reg <= cdh_pkg::SETUP_CYC - 1'b1;
				ST_STROBE, ST_DMA_STROBE: cnt_reg <= cdh_pkg::STROBE_CYC - 1'b1;
				ST_HOLD, ST_DMA_RECOV: cnt_reg <= cdh_pkg::HOLD_CYC - 1'b1;
				default: cnt_reg <= '0;
			endcase
		end else if (!done) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end
	// command capture and word countdown
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			kind_reg <= cdh_pkg::CMD_REG_READ;
			ctrl_reg <= 1'b0;
			addr_reg <= cdh_pkg::ADDR_IDLE;
			wdata_reg <= cdh_pkg::DATA_IDLE;
			remain_reg <= '0;
			err_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && cmd_valid_i) begin
			kind_reg <= cmd_kind_i;
			ctrl_reg <= cmd_ctrl_i;
			addr_reg <= cmd_addr_i;
			wdata_reg <= cmd_wdata_i;
			remain_reg <= cmd_count_i;
			err_reg <= !legal;
		end else begin
			if (wr_ready_o && wr_valid_i) begin
				wdata_reg <= wr_data_i;
			end
			if (state_reg == ST_DMA_STROBE && done) begin
				remain_reg <= remain_reg - 1'b1;
			end
		end
	end
	// read data and input acknowledge capture
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_reg <= cdh_pkg::DATA_IDLE;
			ack_seen_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && cmd_valid_i) begin
			rdata_reg <= cdh_pkg::DATA_IDLE;
			ack_seen_reg <= 1'b0;
		end else if (state_reg == ST_STROBE) begin
			if (!ack_n_s) begin
				ack_seen_reg <= 1'b1;
			end
			if (done) begin
				if (kind_reg == cdh_pkg::CMD_REG_READ) begin
					rdata_reg <= {cdh_pkg::BYTE_PAD, data_s[7:0]};
				end else if (kind_reg == cdh_pkg::CMD_IO_READ && (ack_seen_reg || !ack_n_s)) begin
					rdata_reg <= data_s;
				end
			end
		end
	end
	// decode of the operation in flight
	assign in_cycle = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) ||
		(state_reg == ST_HOLD);
	assign is_reg_op = (kind_reg == cdh_pkg::CMD_REG_READ) ||
		(kind_reg == cdh_pkg::CMD_REG_WRITE);
	assign is_read_op = (kind_reg == cdh_pkg::CMD_REG_READ) ||
		(kind_reg == cdh_pkg::CMD_IO_READ);
	assign in_dma = (state_reg == ST_DMA_SETUP) || (state_reg == ST_DMA_STROBE) ||
		(state_reg == ST_DMA_RECOV);
	// registered card pins, one cycle behind the state
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			addr_o <= cdh_pkg::ADDR_IDLE;
			taskfile_select_n_o <= cdh_pkg::STROBE_IDLE_N;
			control_block_select_n_o <= cdh_pkg::STROBE_IDLE_N;
			card_enable_n_o <= cdh_pkg::CARD_ENABLE_IDLE_N;
			attr_select_n_o <= cdh_pkg::STROBE_IDLE_N;
			io_read_strobe_n_o <= cdh_pkg::STROBE_IDLE_N;
			io_write_strobe_n_o <= cdh_pkg::STROBE_IDLE_N;
			dma_read_strobe_n_o <= cdh_pkg::STROBE_IDLE_N;
			dma_write_strobe_n_o <= cdh_pkg::STROBE_IDLE_N;
			dma_ack_n_o <= cdh_pkg::ACK_IDLE_N;
		end else begin
			addr_o <= in_cycle ? addr_reg : cdh_pkg::ADDR_IDLE;
			// selects stay negated outside register cycles, so also in dma
			taskfile_select_n_o <= !(in_cycle && is_reg_op && !ctrl_reg);
			control_block_select_n_o <= !(in_cycle && is_reg_op && ctrl_reg);
			card_enable_n_o <= (in_cycle && kind_reg == cdh_pkg::CMD_IO_READ) ?
				cdh_pkg::CARD_ENABLE_WORD_N : cdh_pkg::CARD_ENABLE_IDLE_N;
			attr_select_n_o <= !(in_cycle && kind_reg == cdh_pkg::CMD_IO_READ);
			io_read_strobe_n_o <= !(state_reg == ST_STROBE && is_read_op);
			io_write_strobe_n_o <= !(state_reg == ST_STROBE && kind_reg == cdh_pkg::CMD_REG_WRITE);
			dma_read_strobe_n_o <= !(state_reg == ST_DMA_STROBE &&
				kind_reg == cdh_pkg::CMD_DMA_READ);
			dma_write_strobe_n_o <= !(state_reg == ST_DMA_STROBE &&
				kind_reg == cdh_pkg::CMD_DMA_WRITE);
			dma_ack_n_o <= !in_dma;
		end
	end
	// registered data bus drive
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			data_o <= cdh_pkg::DATA_IDLE;
			data_oe_o <= 1'b0;
		end else if (in_cycle && kind_reg == cdh_pkg::CMD_REG_WRITE) begin
			data_o <= {cdh_pkg::BYTE_PAD, wdata_reg[7:0]};
			data_oe_o <= 1'b1;
		end else if ((state_reg == ST_DMA_STROBE || state_reg == ST_DMA_RECOV) &&
			kind_reg == cdh_pkg::CMD_DMA_WRITE) begin
			data_o <= wdata_reg;
			data_oe_o <= 1'b1;
		end else begin
			data_o <= cdh_pkg::DATA_IDLE;
			data_oe_o <= 1'b0;
		end
	end

	// user-side handshakes and status
	assign cmd_ready_o = (state_reg == ST_IDLE);
	assign rsp_valid_o = (state_reg == ST_RESP);
	assign rsp_data_o = rdata_reg;
	assign rsp_error_o = err_reg;
	assign rsp_ack_seen_o = ack_seen_reg;
	assign wr_ready_o = (state_reg == ST_DMA_SETUP) && done &&
		(kind_reg == cdh_pkg::CMD_DMA_WRITE);
	assign dma_available_o = cdh_pkg::DMA_SUPPORTED;
	assign dma_busy_o = in_dma;

	// dma read stream buffer, full words only
	cdh_fifo #(
		.WIDTH(cdh_pkg::DATA_W),
		.DEPTH(cdh_pkg::FIFO_DEPTH)
	) u_rd_fifo (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(data_s),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o)
	);
endmodule // cdh_card_host

/* File: testbench/cdh_card_model.sv */
// Purpose: behavioural card on the far side of the host port
// Assumes: sampled on the host clock; load_i starts a new dma job
// Notes: undriven data shows the inverse of the last driven value
`timescale 1ns/1ps
module cdh_card_model #(
	parameter logic [3:0] IO_ADDR = 4'h3,
	parameter logic [15:0] REG_VAL = 16'ha5c3,
	parameter logic [15:0] IO_VAL = 16'h1e2d,
	parameter logic [15:0] DMA_BASE = 16'h4b00
) (
	input wire logic clock_i,
	input wire cdh_pkg::cdh_mode_e mode_i,
	input wire logic load_i,
	input wire logic [7:0] words_i,
	input wire logic slow_i,
	input wire logic sel_i,
	input wire logic [3:0] addr_i,
	input wire logic sel_n_i,
	input wire logic [1:0] ce_n_i,
	input wire logic attr_n_i,
	input wire logic io_rd_n_i,
	input wire logic dma_rd_n_i,
	input wire logic dma_wr_n_i,
	input wire logic dma_ack_n_i,
	input wire logic [15:0] data_i,
	output logic req_o,
	output logic req_oe_o,
	output logic input_ack_n_o,
	output logic [15:0] data_o
);
	logic [7:0] left_reg, idx_reg;
	logic [2:0] pause_reg;
	logic str_n_reg;
	logic [15:0] last_reg;
	logic [15:0] wr_log [0:15];
	logic io_hit, reg_hit, dma_hit, word_end;
	// decode io reads only in io mode; memory-only mode ignores the strobe
	assign io_hit = mode_i == cdh_pkg::MODE_IO_CARD && !io_rd_n_i && !attr_n_i &&
		ce_n_i != 2'b11 && addr_i == IO_ADDR;
	assign reg_hit = mode_i == cdh_pkg::MODE_DISK_EMULATION && !io_rd_n_i && !sel_n_i;
	assign dma_hit = !dma_rd_n_i && !dma_ack_n_i;
	assign word_end = dma_rd_n_i && dma_wr_n_i && !str_n_reg && !dma_ack_n_i;
	// acknowledge follows strobe and select with no extension
	assign input_ack_n_o = !io_hit;
	// drive read data only under a read strobe
	assign data_o = io_hit ? IO_VAL : reg_hit ? REG_VAL :
		dma_hit ? DMA_BASE + {8'h00, idx_reg} : ~last_reg;
	assign req_oe_o = sel_i;
	// word counting and write capture
	always_ff @(posedge clock_i) begin
		str_n_reg <= dma_rd_n_i & dma_wr_n_i;
		if (io_hit || reg_hit || dma_hit) begin
			last_reg <= data_o;
		end
		if (!dma_wr_n_i && !dma_ack_n_i) begin
			wr_log[idx_reg[3:0]] <= data_i;
		end
		if (load_i) begin
			left_reg <= words_i;
			idx_reg <= 8'h00;
			pause_reg <= 3'h0;
		end else if (word_end) begin
			left_reg <= left_reg - 8'h01;
			idx_reg <= idx_reg + 8'h01;
			pause_reg <= slow_i ? 3'h5 : 3'h0;
		end else if (pause_reg != 3'h0) begin
			pause_reg <= pause_reg - 3'h1;
		end
	end
	// request held until acknowledged, raised again while words remain
	// a slow card drops it from each strobe on, so the host sees the pause in time
	always_ff @(posedge clock_i) begin
		req_o <= !load_i && ((req_o && dma_ack_n_i) ||
			(mode_i == cdh_pkg::MODE_DISK_EMULATION && left_reg != 8'h00 &&
			pause_reg == 3'h0 && !word_end &&
			(!slow_i || (str_n_reg && dma_rd_n_i && dma_wr_n_i))));
	end
endmodule // cdh_card_model

/* File: testbench/cdh_card_host_chk.sv */
// Purpose: pin-level checks on the card host controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every controller instance
`timescale 1ns/1ps
module cdh_card_host_chk (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire cdh_pkg::cdh_mode_e mode_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire logic rsp_error_o,
	input wire logic taskfile_select_n_o,
	input wire logic control_block_select_n_o,
	input wire logic attr_select_n_o,
	input wire logic io_read_strobe_n_o,
	input wire logic io_write_strobe_n_o,
	input wire logic dma_read_strobe_n_o,
	input wire logic dma_write_strobe_n_o,
	input wire logic dma_ack_n_o,
	input wire logic dma_request_i,
	input wire logic [cdh_pkg::DATA_W-1:0] data_o,
	input wire logic data_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// strobe low for eight cycles then released
	sequence low8(s);
		!s [*8] ##1 s;
	endsequence
	chk_dma_selects: assert property (
		!dma_ack_n_o |-> taskfile_select_n_o && control_block_select_n_o)
		else $error("register select active during dma");
	chk_ack_on_req: assert property (
		$fell(dma_ack_n_o) |-> $past(dma_request_i, 2))
		else $error("dma acknowledge without request");
	chk_strobe_ack: assert property (
		!dma_read_strobe_n_o || !dma_write_strobe_n_o |-> !dma_ack_n_o)
		else $error("dma strobe outside acknowledge");
	chk_dwr_word: assert property (
		$fell(dma_write_strobe_n_o) |-> data_oe_o throughout low8(dma_write_strobe_n_o))
		else $error("dma write word malformed");
	chk_io_attr: assert property (
		!io_read_strobe_n_o && mode_i == cdh_pkg::MODE_IO_CARD |-> !attr_select_n_o)
		else $error("attribute select high in io read");
	chk_reg_select: assert property (
		!io_write_strobe_n_o |-> taskfile_select_n_o ^ control_block_select_n_o)
		else $error("not exactly one register select");
	chk_reg_lane: assert property (
		!io_write_strobe_n_o |-> data_oe_o && data_o[15:8] == cdh_pkg::BYTE_PAD)
		else $error("register write not on low byte lane");
	chk_read_release: assert property (
		!io_read_strobe_n_o || !dma_read_strobe_n_o |-> !data_oe_o)
		else $error("host drives bus during read");
	chk_mem_refused: assert property (
		cmd_valid_i && cmd_ready_o && mode_i == cdh_pkg::MODE_MEMORY_ONLY
		|-> ##1 rsp_valid_o && rsp_error_o && io_read_strobe_n_o)
		else $error("memory-only command not refused");
endmodule // cdh_card_host_chk
bind cdh_card_host cdh_card_host_chk chk (.*);

/* File: testbench/test_cdh_card_host.sv */
// Purpose: self-checking bench for the card host controller
// Assumes: 100 MHz clock, behavioural card on the pin side
// Notes: dma request pulled low while the card leaves it undriven
`timescale 1ns/1ps
module test_cdh_card_host;
	logic clock_i, nrst_i = 1'b0, cmd_valid_i = 1'b0, cmd_ctrl_i = 1'b0, load = 1'b1;
	logic rd_ready_i = 1'b0, wr_valid_i = 1'b0, slow = 1'b0, req, req_oe;
	cdh_pkg::cdh_mode_e mode_i = cdh_pkg::MODE_MEMORY_ONLY;
	cdh_pkg::cdh_cmd_e cmd_kind_i = cdh_pkg::CMD_REG_READ;
	logic [3:0] cmd_addr_i = 4'h0, addr_o;
	logic [7:0] cmd_count_i = 8'h00;
	logic [15:0] cmd_wdata_i = 16'hc3a5, wr_data_i = 16'h0000, rsp_data_o, rd_data_o;
	logic [15:0] data_i, data_o, card_data;
	logic cmd_ready_o, rsp_valid_o, rsp_error_o, rsp_ack_seen_o, rd_valid_o, wr_ready_o;
	logic dma_available_o, dma_busy_o, taskfile_select_n_o, control_block_select_n_o;
	logic [1:0] card_enable_n_o;
	logic attr_select_n_o, io_read_strobe_n_o, io_write_strobe_n_o, dma_read_strobe_n_o;
	logic dma_write_strobe_n_o, dma_ack_n_o, dma_request_i, input_ack_n_i, data_oe_o;
	int error_cnt = 0, tests_run = 0, cycles = 0, ack_rel = 0;
	logic ack_q = 1'b1, card_sel;
	logic [15:0] got [$];
	// bus resolution and request pull-down
	assign data_i = data_oe_o ? data_o : card_data;
	assign dma_request_i = req_oe ? req : 1'b0;
	// the card counts as selected only in disk emulation mode
	assign card_sel = (mode_i == cdh_pkg::MODE_DISK_EMULATION);
	cdh_card_host dut (.*);
	cdh_card_model card (.clock_i(clock_i), .mode_i(mode_i), .load_i(load),
		.words_i(cmd_count_i), .slow_i(slow), .sel_i(card_sel), .addr_i(addr_o),
		.sel_n_i(taskfile_select_n_o & control_block_select_n_o), .ce_n_i(card_enable_n_o),
		.attr_n_i(attr_select_n_o), .io_rd_n_i(io_read_strobe_n_o),
		.dma_rd_n_i(dma_read_strobe_n_o), .dma_wr_n_i(dma_write_strobe_n_o),
		.dma_ack_n_i(dma_ack_n_o), .data_i(data_i), .req_o(req), .req_oe_o(req_oe),
		.input_ack_n_o(input_ack_n_i), .data_o(card_data));
	// clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// hang guard
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	// count releases of the dma acknowledge pin
	always @(posedge clock_i) begin
		ack_q <= dma_ack_n_o;
		if (dma_ack_n_o === 1'b1 && ack_q === 1'b0) ack_rel++;
	end
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// one command, waits for its response
	task automatic run_cmd(input cdh_pkg::cdh_mode_e m, input cdh_pkg::cdh_cmd_e k,
		input logic c, input logic [3:0] a, input logic [7:0] n);
		int i;
		@(posedge clock_i);
		mode_i <= m;
		cmd_kind_i <= k;
		cmd_ctrl_i <= c;
		cmd_addr_i <= a;
		cmd_count_i <= n;
		cmd_valid_i <= 1'b1;
		load <= 1'b1;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		load <= 1'b0;
		for (i = 0; i < 4000; i++) begin
			@(negedge clock_i);
			if (rsp_valid_o === 1'b1) break;
		end
		check(16'(rsp_valid_o), 16'h0001);
	endtask
	task automatic t_reset();
		check({14'h0, card_enable_n_o}, 16'h0003);
		check(16'(dma_ack_n_o), 16'h0001);
		check(16'(dma_available_o), 16'h0001);
		check(16'(dma_request_i), 16'h0000);
	endtask
	task automatic t_illegal();
		for (int i = 0; i < 5; i++) begin
			run_cmd(cdh_pkg::MODE_MEMORY_ONLY, cdh_pkg::cdh_cmd_e'(i), 1'b0, 4'h3, 8'h02);
			check(16'(rsp_error_o), 16'h0001);
		end
		run_cmd(cdh_pkg::MODE_DISK_EMULATION, cdh_pkg::CMD_DMA_READ, 1'b0, 4'h0, 8'h00);
		check(16'(rsp_error_o), 16'h0001);
	endtask
	task automatic t_io();
		run_cmd(cdh_pkg::MODE_IO_CARD, cdh_pkg::CMD_IO_READ, 1'b0, card.IO_ADDR, 8'h00);
		check(rsp_data_o, card.IO_VAL);
		check({14'h0, rsp_error_o, rsp_ack_seen_o}, 16'h0001);
		run_cmd(cdh_pkg::MODE_IO_CARD, cdh_pkg::CMD_IO_READ, 1'b0, 4'h5, 8'h00);
		check(rsp_data_o, 16'h0000);
		check({14'h0, rsp_error_o, rsp_ack_seen_o}, 16'h0000);
	endtask
	task automatic t_reg();
		for (int c = 0; c < 2; c++) begin
			run_cmd(cdh_pkg::MODE_DISK_EMULATION, cdh_pkg::CMD_REG_WRITE, c[0], 4'h6, 8'h00);
			check(16'(rsp_error_o), 16'h0000);
			run_cmd(cdh_pkg::MODE_DISK_EMULATION, cdh_pkg::CMD_REG_READ, c[0], 4'h7, 8'h00);
			check(rsp_data_o, {8'h00, card.REG_VAL[7:0]});
		end
	endtask
	// three words with the card pausing its request between them
	task automatic t_dma_write();
		int rel0;
		rel0 = ack_rel;
		slow <= 1'b1;
		fork
			run_cmd(cdh_pkg::MODE_DISK_EMULATION, cdh_pkg::CMD_DMA_WRITE, 1'b0, 4'h0, 8'h03);
			for (int k = 0; k < 3; k++) begin
				@(posedge clock_i);
				wr_data_i <= 16'h9100 + 16'(k);
				wr_valid_i <= 1'b1;
				do @(negedge clock_i); while (wr_ready_o !== 1'b1);
			end
		join
		wr_valid_i <= 1'b0;
		slow <= 1'b0;
		repeat (2) @(negedge clock_i);
		// two pauses and the final release
		check(16'(ack_rel - rel0), 16'h0003);
		for (int k = 0; k < 3; k++) begin
			check(card.wr_log[k], 16'h9100 + 16'(k));
		end
	endtask
	// ten words into a stalled stream, then drained
	task automatic t_dma_read();
		got.delete();
		fork
			run_cmd(cdh_pkg::MODE_DISK_EMULATION, cdh_pkg::CMD_DMA_READ, 1'b0, 4'h0, 8'h0a);
			begin
				repeat (200) @(negedge clock_i);
				check({14'h0, rd_valid_o, dma_busy_o}, 16'h0003);
				@(posedge clock_i);
				rd_ready_i <= 1'b1;
				while (got.size() < 10) begin
					@(negedge clock_i);
					if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
				end
			end
		join
		for (int k = 0; k < 10; k++) begin
			check(got[k], card.DMA_BASE + 16'(k));
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(negedge clock_i);
		t_reset();
		t_illegal();
		t_io();
		t_reg();
		t_dma_write();
		t_dma_read();
		stop_test();
	end
endmodule // test_cdh_card_host
